//--- hdl/prl_pkg.sv
// Package with the constants shared by the reset and link-clock control block.
package prl_pkg;

  // ==========================================================================
  // System clock
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 25;      // System clock period at 40 MHz.

  // ==========================================================================
  // Power-on reset
  // ==========================================================================
  // Time the sensed supply must stay good before the master reset is released.
  localparam int POR_STABLE_NS  = 1000;
  localparam int POR_STABLE_CYC = (POR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W      = 6;
  localparam logic [POR_CNT_W-1:0] POR_CNT_LAST = POR_CNT_W'(POR_STABLE_CYC - 1);
  localparam logic [POR_CNT_W-1:0] POR_CNT_ZERO = 6'h00;

  // Power-on reset sequencer states.
  typedef enum logic [1:0] {
    POR_HOLD  = 2'b00,
    POR_COUNT = 2'b01,
    POR_DONE  = 2'b10
  } prl_por_state_t;

  // ==========================================================================
  // Controller reset/sync pin filter
  // ==========================================================================
  localparam int RSF_FILT_NS  = 200;      // Shorter low pulses are sync pulses.
  localparam int RSF_FILT_CYC = (RSF_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSF_CNT_W    = 4;
  localparam logic [RSF_CNT_W-1:0] RSF_CNT_LAST = RSF_CNT_W'(RSF_FILT_CYC - 1);
  localparam logic [RSF_CNT_W-1:0] RSF_CNT_ZERO = 4'h0;
  localparam logic [RSF_CNT_W-1:0] RSF_CNT_ONE  = 4'h1;

  // ==========================================================================
  // Management write decode and software reset
  // ==========================================================================
  localparam int MGMT_ADDR_W = 5;
  localparam int MGMT_DATA_W = 16;
  localparam logic [MGMT_ADDR_W-1:0] CTRL_REG_ADDR = 5'h00;
  localparam int SOFT_RST_BIT = 15;
  localparam int SOFT_CNT_W   = 3;
  localparam logic [SOFT_CNT_W-1:0] SOFT_RST_CYC = 3'h4;
  localparam logic [SOFT_CNT_W-1:0] SOFT_CNT_ZERO = 3'h0;
  localparam logic [SOFT_CNT_W-1:0] SOFT_CNT_ONE  = 3'h1;

  // ==========================================================================
  // Straps
  // ==========================================================================
  localparam int STRAP_W = 4;
  localparam logic [STRAP_W-1:0] STRAP_RST = 4'h0;

  // ==========================================================================
  // Link clock divider (source clock assumed at 100 MHz)
  // ==========================================================================
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] FAST_HALF_LAST = 4'h0;  // 50 MHz: toggle every source cycle.
  localparam logic [DIV_W-1:0] SLOW_HALF_LAST = 4'h9;  // 5 MHz: toggle every ten cycles.
  localparam logic [DIV_W-1:0] DIV_ZERO       = 4'h0;
  localparam logic [DIV_W-1:0] DIV_ONE        = 4'h1;

endpackage : prl_pkg

//--- hdl/prl_sync2.sv
// Two-flop synchroniser with a constant reset value.
`timescale 1ns/100ps
`default_nettype none

module prl_sync2 #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;  // First stage, read only by the second stage.

  // ==========================================================================
  // Synchroniser stages
  // ==========================================================================
  // Both stages take the constant under reset, never a port value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : prl_sync2

`default_nettype wire

//--- hdl/prl_ctrl.sv
// Reset sequencing, strap capture and link clock generation for the PHY.
//
// Function
// - Hold master reset until supply stable.
// - Capture straps when power-on reset releases.
// - Reset/sync pin resets whole device.
// - Control bit 15 resets PHY only.
// - Only power-on reset recaptures straps.
// - Link clock rate never changes mid-cycle.
// - Halted link clock is held low.
// - Link outputs always driven to defined levels.
// - Link clock halts only on power-on reset.
// - Ignore reset/sync pulses shorter than 200 ns.
// - 50 MHz at 100 Mb/s without reduced power, else 5 MHz.
`timescale 1ns/100ps
`default_nettype none

module prl_ctrl (
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic                               link_src_clk,
  input  wire logic                               supply_good,
  input  wire logic                               link_reset_sync_in,
  input  wire logic [prl_pkg::STRAP_W-1:0]        strap_in,
  input  wire logic                               mgmt_wr_en,
  input  wire logic [prl_pkg::MGMT_ADDR_W-1:0]    mgmt_addr,
  input  wire logic [prl_pkg::MGMT_DATA_W-1:0]    mgmt_wdata,
  input  wire logic                               speed_100,
  input  wire logic                               reduced_power,
  output var  logic                               por_n,
  output var  logic                               dev_rst_n,
  output var  logic                               phy_rst_n,
  output var  logic [prl_pkg::STRAP_W-1:0]        strap_out,
  output var  logic                               link_clock_out
);
  import prl_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic               supply_s;   // Supply sense after two flops.
  logic               rsync_s;    // Reset/sync pin after two flops.
  logic [STRAP_W-1:0] strap_s;    // Strap pins after two flops.

  // The supply sense is taken as bad until proven good.
  prl_sync2 #(.W(1), .RST_VAL(1'b0)) u_sync_supply (
    .clk (clk),
    .rst (rst),
    .d   (supply_good),
    .q   (supply_s)
  );

  // The reset/sync pin idles high through its pull-up.
  prl_sync2 #(.W(1), .RST_VAL(1'b1)) u_sync_rsync (
    .clk (clk),
    .rst (rst),
    .d   (link_reset_sync_in),
    .q   (rsync_s)
  );

  // Straps are static, so a plain two-flop stage per bit is enough.
  prl_sync2 #(.W(STRAP_W), .RST_VAL(STRAP_RST)) u_sync_strap (
    .clk (clk),
    .rst (rst),
    .d   (strap_in),
    .q   (strap_s)
  );

  // ==========================================================================
  // Power-on reset sequencer
  // ==========================================================================
  prl_por_state_t       por_state_r;   // Sequencer state.
  prl_por_state_t       por_state_nxt; // Next sequencer state.
  logic [POR_CNT_W-1:0] por_cnt_r;     // Cycles of good supply seen so far.
  logic [POR_CNT_W-1:0] por_cnt_nxt;
  logic                 por_n_r;       // Master reset, active low.
  logic                 por_n_nxt;
  logic                 por_rel_w;     // One-cycle release strobe.

  // Any dip of the supply restarts the whole stable-time count.
  always_comb begin
    por_state_nxt = por_state_r;
    por_cnt_nxt   = POR_CNT_ZERO;
    case (por_state_r)
      POR_HOLD: begin
        if (supply_s) begin
          por_state_nxt = POR_COUNT;
        end
      end
      POR_COUNT: begin
        if (!supply_s) begin
          por_state_nxt = POR_HOLD;
        end else if (por_cnt_r == POR_CNT_LAST) begin
          por_state_nxt = POR_DONE;
        end else begin
          por_cnt_nxt = por_cnt_r + POR_CNT_W'(1);
        end
      end
      POR_DONE: begin
        if (!supply_s) begin
          por_state_nxt = POR_HOLD;
        end
      end
      default: begin
        por_state_nxt = POR_HOLD;
      end
    endcase
  end

  // The release comes from a flop on clk, so every consumer sees a clean edge.
  assign por_n_nxt = (por_state_nxt == POR_DONE);
  assign por_rel_w = por_n_nxt && !por_n_r;

  // Sequencer registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      por_state_r <= POR_HOLD;
      por_cnt_r   <= POR_CNT_ZERO;
      por_n_r     <= 1'b0;
    end else begin
      por_state_r <= por_state_nxt;
      por_cnt_r   <= por_cnt_nxt;
      por_n_r     <= por_n_nxt;
    end
  end

  // ==========================================================================
  // Strap capture
  // ==========================================================================
  logic [STRAP_W-1:0] strap_r;  // Captured strap values.

  // Straps load only on power-on release; the other resets leave them alone.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_r <= STRAP_RST;
    end else if (por_rel_w) begin
      strap_r <= strap_s;
    end
  end

  // ==========================================================================
  // Reset/sync pin filter
  // ==========================================================================
  logic [RSF_CNT_W-1:0] rsf_cnt_r;      // Consecutive low samples, saturating.
  logic [RSF_CNT_W-1:0] rsf_cnt_nxt;
  logic                 rsf_active_r;   // A genuine controller reset is in force.
  logic                 rsf_active_nxt;

  // A low shorter than the filter is a sync pulse and is simply dropped.
  assign rsf_cnt_nxt    = rsync_s ? RSF_CNT_ZERO :
                          (rsf_cnt_r == RSF_CNT_LAST) ? rsf_cnt_r : (rsf_cnt_r + RSF_CNT_ONE);
  assign rsf_active_nxt = !rsync_s && ((rsf_cnt_r == RSF_CNT_LAST) || rsf_active_r);

  // Filter registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsf_cnt_r    <= RSF_CNT_ZERO;
      rsf_active_r <= 1'b0;
    end else begin
      rsf_cnt_r    <= rsf_cnt_nxt;
      rsf_active_r <= rsf_active_nxt;
    end
  end

  // ==========================================================================
  // Software reset and reset outputs
  // ==========================================================================
  logic                  soft_req_w;    // Write of one to the reset bit.
  logic [SOFT_CNT_W-1:0] soft_cnt_r;    // Remaining software reset cycles.
  logic [SOFT_CNT_W-1:0] soft_cnt_nxt;
  logic                  dev_rst_n_nxt;
  logic                  phy_rst_n_nxt;
  logic                  dev_rst_n_r;
  logic                  phy_rst_n_r;

  // A write while the device itself is in reset has no one to act on.
  assign soft_req_w    = mgmt_wr_en && (mgmt_addr == CTRL_REG_ADDR) &&
                         mgmt_wdata[SOFT_RST_BIT] && dev_rst_n_r;
  assign soft_cnt_nxt  = soft_req_w ? SOFT_RST_CYC :
                         (soft_cnt_r != SOFT_CNT_ZERO) ? (soft_cnt_r - SOFT_CNT_ONE) : SOFT_CNT_ZERO;
  assign dev_rst_n_nxt = por_n_nxt && !rsf_active_nxt;
  assign phy_rst_n_nxt = dev_rst_n_nxt && (soft_cnt_nxt == SOFT_CNT_ZERO);

  // Reset output registers; the software reset never reaches dev_rst_n.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_cnt_r  <= SOFT_CNT_ZERO;
      dev_rst_n_r <= 1'b0;
      phy_rst_n_r <= 1'b0;
    end else begin
      soft_cnt_r  <= soft_cnt_nxt;
      dev_rst_n_r <= dev_rst_n_nxt;
      phy_rst_n_r <= phy_rst_n_nxt;
    end
  end

  // ==========================================================================
  // Rate request toward the link domain
  // ==========================================================================
  logic fast_req_r;  // High asks for the fast link clock.

  // Registered so the crossing sees a single glitch-free level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_req_r <= 1'b0;
    end else begin
      fast_req_r <= speed_100 && !reduced_power;
    end
  end

  // ==========================================================================
  // Link clock domain
  // ==========================================================================
  logic             link_arst_w;   // Asserts at once when power is lost.
  logic             link_run_s;    // Released synchronously on link_src_clk.
  logic             fast_s;        // Rate request after two flops.
  logic             cur_fast_r;    // Rate in force for the current cycle.
  logic [DIV_W-1:0] div_cnt_r;     // Source cycles into the current half.
  logic [DIV_W-1:0] half_last_w;
  logic             half_end_w;
  logic             clk_out_r;     // Link clock level.
  logic [DIV_W-1:0] stall_cnt_r;   // Source cycles since the pin last moved.
  logic             clk_out_d_r;   // Link clock level one source cycle ago.

  assign link_arst_w = rst || !por_n_r;

  // Only the power-on reset stops the link clock, so it runs through the
  // controller reset and the software reset as the controller expects.
  prl_sync2 #(.W(1), .RST_VAL(1'b0)) u_sync_link_run (
    .clk (link_src_clk),
    .rst (link_arst_w),
    .d   (1'b1),
    .q   (link_run_s)
  );

  prl_sync2 #(.W(1), .RST_VAL(1'b0)) u_sync_fast (
    .clk (link_src_clk),
    .rst (link_arst_w),
    .d   (fast_req_r),
    .q   (fast_s)
  );

  assign half_last_w = cur_fast_r ? FAST_HALF_LAST : SLOW_HALF_LAST;
  assign half_end_w  = (div_cnt_r == half_last_w);

  // The rate is only swapped at the rising edge that closes a full low half,
  // so no shortened high or low time ever appears on the pin.
  always_ff @(posedge link_src_clk or posedge link_arst_w) begin
    if (link_arst_w) begin
      clk_out_r  <= 1'b0;
      div_cnt_r  <= DIV_ZERO;
      cur_fast_r <= 1'b0;
    end else if (link_run_s) begin
      if (half_end_w) begin
        clk_out_r <= !clk_out_r;
        div_cnt_r <= DIV_ZERO;
        if (!clk_out_r) begin
          cur_fast_r <= fast_s;
        end
      end else begin
        div_cnt_r <= div_cnt_r + DIV_ONE;
      end
    end
  end

  // Helper count watching the pin itself, so a divider that stops toggling is caught.
  always_ff @(posedge link_src_clk or posedge link_arst_w) begin
    if (link_arst_w) begin
      clk_out_d_r <= 1'b0;
      stall_cnt_r <= DIV_ZERO;
    end else begin
      clk_out_d_r <= clk_out_r;
      stall_cnt_r <= ((clk_out_r != clk_out_d_r) || !link_run_s) ? DIV_ZERO : (stall_cnt_r + DIV_ONE);
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign por_n          = por_n_r;
  assign dev_rst_n      = dev_rst_n_r;
  assign phy_rst_n      = phy_rst_n_r;
  assign strap_out      = strap_r;
  assign link_clock_out = clk_out_r;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_short_low;
    rsync_s ##1 (!rsync_s)[*7] ##1 rsync_s;
  endsequence
  sequence s_long_low;
    (!rsync_s)[*8];
  endsequence
  sequence s_soft_pulse;
    (!phy_rst_n_r && dev_rst_n_r)[*4];
  endsequence

  a_por_supply_loss: assert property (@(posedge clk) disable iff (rst)
    !supply_s |=> !por_n_r && !dev_rst_n_r && !phy_rst_n_r)
    else $error("master reset not asserted after supply loss");
  a_strap_capture: assert property (@(posedge clk) disable iff (rst)
    $rose(por_n_r) |-> strap_r == $past(strap_s))
    else $error("straps not captured at power-on release");
  a_strap_hold_stable: assert property (@(posedge clk) disable iff (rst)
    por_n_r && $past(por_n_r) |-> $stable(strap_r))
    else $error("straps changed without a power-on reset");
  a_rsync_long_reset: assert property (@(posedge clk) disable iff (rst)
    s_long_low |=> !dev_rst_n_r && !phy_rst_n_r)
    else $error("controller reset did not reset the device");
  a_rsync_sync_ignored: assert property (@(posedge clk) disable iff (rst)
    s_short_low |-> !rsf_active_r ##1 (dev_rst_n_r == $past(por_n_nxt)))
    else $error("short sync pulse treated as reset");
  a_soft_phy_only: assert property (@(posedge clk) disable iff (rst)
    soft_req_w && !rsf_active_nxt && por_n_nxt |=> s_soft_pulse)
    else $error("software reset width or scope wrong");
  a_link_halt_low: assert property (@(posedge link_src_clk) disable iff (rst)
    !link_run_s |-> !clk_out_r)
    else $error("link clock halted high");
  // The first low half after start is one source cycle longer, hence the extra count.
  a_link_no_halt: assert property (@(posedge link_src_clk) disable iff (link_arst_w)
    link_run_s |-> stall_cnt_r <= (SLOW_HALF_LAST + DIV_ONE))
    else $error("link clock stalled while running");

  a_rate_at_rise: assert property (@(posedge link_src_clk) disable iff (link_arst_w)
    $changed(cur_fast_r) |-> $rose(clk_out_r))
    else $error("link clock rate changed mid-cycle");

endmodule : prl_ctrl

`default_nettype wire

//--- testbench/prl_mac_model.sv
// Behavioural model of the media access controller on the far side of the link.
`timescale 1ns/100ps
`default_nettype none

module prl_mac_model (
  input  wire logic clk,
  input  wire logic supply_good,
  input  wire logic link_clock_out,
  output var  logic link_reset_sync_in
);
  // ==========================================================================
  // Link clock observation
  // ==========================================================================
  int  edges    = 0;    // Rising edges of the link clock seen.
  int  period   = 0;    // Last full period, in 100 ps units.
  int  bad_half = 0;    // Half periods of neither legal width.
  int  w;               // Width of the half period just ended.
  real last_edge = 0.0; // Time of the last rising edge.
  real last_chg  = 0.0; // Time of the last edge of either kind.
  real stable_t  = 0.0; // Start of the current unbroken run of the clock.
  real pwr_t     = 0.0; // Time at which the supply last came up.

  // The pin is always driven, never left floating.
  initial link_reset_sync_in = 1'b1;

  // Power-up time, so that no pulse starts too early.
  always @(posedge supply_good) pwr_t = $realtime;

  // A gap over 300 ns counts as a stop; shorter halves must be 12 ns or 120 ns.
  // The first settle out of the unknown power-up level is not a half period.
  always @(link_clock_out) begin
    w = $rtoi(($realtime - last_chg) * 10.0 + 0.5);
    if (w > 3000 || last_chg == 0.0) stable_t = $realtime;
    else if (w != 120 && w != 1200) bad_half++;
    last_chg = $realtime;
  end

  // Period of each full cycle, taken at the rising edge.
  always @(posedge link_clock_out) begin
    period = $rtoi(($realtime - last_edge) * 10.0 + 0.5);
    last_edge = $realtime;
    edges++;
  end

  // Low pulse of at least cyc cycles; a pulse of 20000 or more cycles also waits for a stable clock.
  task automatic pulse(input int cyc, output int held);
    @(negedge clk);
    while ($realtime - pwr_t < 1000000.0) @(negedge clk);
    link_reset_sync_in = 1'b0;
    held = 0;
    while (held < cyc || (cyc >= 20000 && $realtime - stable_t < 500000.0)) begin
      @(negedge clk);
      held++;
    end
    link_reset_sync_in = 1'b1;
  endtask : pulse
endmodule : prl_mac_model
`default_nettype wire

//--- testbench/test_phy_reset_and_link_clock_control.sv
// Self-checking testbench for the reset and link-clock control block.
`timescale 1ns/100ps
`default_nettype none

module test_phy_reset_and_link_clock_control;
  import prl_pkg::*;
  // ==========================================================================
  // Signals and bench state
  // ==========================================================================
  logic        clk = 1'b0, link_src_clk = 1'b0, rst = 1'b1, supply_good = 1'b1;
  logic [3:0]  strap_in = 4'h0, strap_out;
  logic        mgmt_wr_en = 1'b0, speed_100 = 1'b1, reduced_power = 1'b0;
  logic [4:0]  mgmt_addr = 5'h00, a;
  logic [15:0] mgmt_wdata = 16'h0000, d;
  logic        por_n, dev_rst_n, phy_rst_n, link_clock_out, pin;
  logic [31:0] seed;
  int          fail_count = 0, num_checks = 0; // Mismatches and comparisons.
  int          dev_low = 0, phy_low = 0, por_low = 0; // Low cycles seen per output.
  int          m_strap, held, n, e0, ex;   // Model state and scratch values.

  // Clocks; the link source has a period unrelated to the system clock.
  always #12.5 clk = ~clk;
  always #6 link_src_clk = ~link_src_clk;

  prl_ctrl u_prl_ctrl (.clk(clk), .rst(rst), .link_src_clk(link_src_clk), .supply_good(supply_good),
    .link_reset_sync_in(pin), .strap_in(strap_in), .mgmt_wr_en(mgmt_wr_en), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .speed_100(speed_100), .reduced_power(reduced_power), .por_n(por_n),
    .dev_rst_n(dev_rst_n), .phy_rst_n(phy_rst_n), .strap_out(strap_out), .link_clock_out(link_clock_out));
  prl_mac_model u_prl_mac_model (.clk(clk), .supply_good(supply_good), .link_clock_out(link_clock_out),
    .link_reset_sync_in(pin));

  // Count low cycles at the falling edge, where outputs have settled.
  always @(negedge clk) begin
    if (dev_rst_n === 1'b0) dev_low++;
    if (phy_rst_n === 1'b0) phy_low++;
    if (por_n === 1'b0) por_low++;
  end

  // ==========================================================================
  // Tasks and model
  // ==========================================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // One management write, strobe high for exactly one clock.
  task automatic wr(input logic [4:0] wa, input logic [15:0] wd);
    @(negedge clk);
    mgmt_wr_en = 1'b1;
    mgmt_addr = wa;
    mgmt_wdata = wd;
    @(negedge clk);
    mgmt_wr_en = 1'b0;
  endtask : wr

  task automatic clr;
    dev_low = 0;
    phy_low = 0;
    por_low = 0;
  endtask : clr

  // Bounded wait for the master reset to release; n counts the cycles.
  task automatic wait_por(output int cnt);
    cnt = 0;
    while (por_n !== 1'b1 && cnt < 200) begin
      @(negedge clk);
      cnt++;
    end
  endtask : wait_por

  // Expected link clock period in 100 ps units for a 12 ns source clock.
  function automatic int exp_period(input logic s, input logic r);
    return (s && !r) ? 240 : 2400;
  endfunction : exp_period

  // Watchdog sized beyond the 1.5 ms the sequence needs, under 100,000 clocks.
  initial begin
    #2200000;
    fail_count++;
    stop_test;
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = $urandom(32'hd985);
    strap_in = 4'($urandom);
    m_strap = strap_in;
    repeat (8) @(negedge clk);
    check("outputs in reset", {por_n, dev_rst_n, phy_rst_n, link_clock_out}, 4'h0);
    rst = 1'b0;
    wait_por(n);
    check("por release time", 32'(n >= 42 && n <= 44), 1);
    check("resets released", {dev_rst_n, phy_rst_n}, 2'h3);
    check("strap capture", strap_out, m_strap);
    strap_in = ~strap_in;
    // Soft reset: single, back to back, wrong address, bit cleared.
    for (int k = 0; k < 4; k++) begin
      d = 16'($urandom) | 16'h8000;
      a = (k == 2) ? 5'($urandom_range(31, 1)) : CTRL_REG_ADDR;
      if (k == 3) d[SOFT_RST_BIT] = 1'b0;
      ex = (k > 1) ? 0 : int'(SOFT_RST_CYC) + ((k == 1) ? 2 : 0);
      clr;
      wr(a, d);
      if (k == 1) wr(a, d);
      repeat (12) @(negedge clk);
      check("soft reset width", phy_low, ex);
      check("soft reset device", dev_low, 0);
    end
    check("strap after soft", strap_out, m_strap);
    // Link clock rate for every mode; the last one is fast.
    for (int k = 3; k < 7; k++) begin
      {speed_100, reduced_power} = 2'(k);
      repeat (60) @(negedge clk);
      check("link clock period", u_prl_mac_model.period, exp_period(speed_100, reduced_power));
    end
    check("clean half periods", u_prl_mac_model.bad_half, 0);
    // Pin pulses: ignored sync, shortest reset, full-length reset.
    for (int k = 0; k < 3; k++) begin
      clr;
      e0 = u_prl_mac_model.edges;
      u_prl_mac_model.pulse((k == 0) ? 7 : (k == 1) ? 8 : 20000, held);
      repeat (4) @(negedge clk);
      ex = (held >= 8) ? held - 7 : 0;
      check("pin device reset", dev_low, ex);
      check("pin phy reset", phy_low, ex);
      check("pin keeps por", por_low, 0);
      check("pin keeps strap", strap_out, m_strap);
      check("clock runs in reset", 32'(u_prl_mac_model.edges - e0 > held / 2), 1);
    end
    // Supply loss: all held, clock stopped low, dip restarts, straps recaptured.
    supply_good = 1'b0;
    repeat (10) @(negedge clk);
    check("supply loss resets", {por_n, dev_rst_n, phy_rst_n}, 3'h0);
    e0 = u_prl_mac_model.edges;
    repeat (20) @(negedge clk);
    check("clock halted", u_prl_mac_model.edges - e0, 0);
    check("clock held low", link_clock_out, 1'b0);
    strap_in = 4'($urandom);
    m_strap = strap_in;
    supply_good = 1'b1;
    repeat (20) @(negedge clk);
    supply_good = 1'b0;
    repeat (2) @(negedge clk);
    supply_good = 1'b1;
    wait_por(n);
    check("por after dip", 32'(n >= 42 && n <= 44), 1);
    check("strap recapture", strap_out, m_strap);
    stop_test;
  end
endmodule : test_phy_reset_and_link_clock_control
`default_nettype wire
